//--- rtl/gpx_pkg.sv
// Shared constants and types of the general-purpose I/O port with external interrupts.
package gpx_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SENS_W = 2;
  localparam int unsigned VEC_IDX_W = 2;
  localparam int unsigned MAX_VEC = 4;

  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_OPT = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_SENS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_PEND = 4'h4;

  // Reset values.
  localparam logic [DATA_W-1:0] RST_LATCH = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIR = 8'h00;
  localparam logic [DATA_W-1:0] RST_OPT = 8'h00;
  localparam logic [DATA_W-1:0] RST_SENS = 8'h00;
  localparam logic [DATA_W-1:0] READ_NONE = 8'h00;

  // The edge detector idles high, the level a disabled pin presents.
  localparam logic IDLE_LEVEL = 1'b1;

  // Default grouping of pins onto vectors, two bits per pin, pin 0 lowest.
  localparam logic [15:0] PIN_VEC_MAP_DEF = 16'h5500;

  typedef enum logic [1:0] {
    SENS_FALL = 2'b00,
    SENS_RISE = 2'b01,
    SENS_BOTH = 2'b10,
    SENS_LOW = 2'b11
  } gpx_sens_type;

endpackage

//--- rtl/gpx_pin_cell.sv
// Combinational mode decode of one port pin.
`timescale 1ns/100ps
module gpx_pin_cell (
  // Configuration bits of this pin
  input wire logic i_latch,
  input wire logic i_dir,
  input wire logic i_opt,
  // Pad and alternate function
  input wire logic i_pin,
  input wire logic i_af_out_en,
  input wire logic i_af_out,
  // Results
  output logic o_out,
  output logic o_oe,
  output logic o_pullup,
  output logic o_read,
  output logic o_af_in,
  output logic o_irq_src
);

  wire logic irq_en;

  // RL5 interrupt input select
  assign irq_en = ~i_dir & i_opt & ~i_af_out_en;
  // RL15 peripheral drives pin
  assign o_out = i_af_out_en ? i_af_out : i_latch;
  // RL14 open-drain releases high
  assign o_oe = i_af_out_en | (i_dir & (i_opt | ~i_latch));
  // RL4 pull-up in input
  assign o_pullup = ~i_dir & i_opt & ~i_af_out_en;
  // RL16 alternate output readback
  assign o_read = i_af_out_en ? i_af_out : (i_dir ? i_latch : i_pin);
  // RL17 latch feeds peripheral
  // RL18 floating input passes
  assign o_af_in = i_dir ? i_latch : i_pin;
  // RL10 disabled source idles high
  assign o_irq_src = irq_en ? i_pin : gpx_pkg::IDLE_LEVEL;

endmodule // gpx_pin_cell

//--- rtl/gpx_ext_irq.sv
// Edge or level detector and pending latch of one external interrupt vector.
`timescale 1ns/100ps
module gpx_ext_irq (
  // Clock and control
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Source and setup
  input wire logic i_source,
  input wire logic [gpx_pkg::SENS_W-1:0] i_sens,
  input wire logic i_sens_change,
  input wire logic i_fetch,
  // Pending request
  output logic o_pending
);

  logic prev;
  logic hit;
  logic next_pending;
  wire logic rise;
  wire logic fall;

  assign rise = ~prev & i_source;
  assign fall = prev & ~i_source;

  // RL6 sensitivity select
  always_comb begin
    case (gpx_pkg::gpx_sens_type'(i_sens))
      gpx_pkg::SENS_FALL: hit = fall;
      gpx_pkg::SENS_RISE: hit = rise;
      gpx_pkg::SENS_BOTH: hit = rise | fall;
      gpx_pkg::SENS_LOW: hit = ~i_source;
      default: hit = 1'b0;
    endcase
  end

  // RL8 fetch clears latch
  // RL9 sensitivity change clears
  assign next_pending = hit | (o_pending & ~(i_fetch | i_sens_change));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prev <= gpx_pkg::IDLE_LEVEL;
      o_pending <= 1'b0;
    end else if (i_ce) begin
      prev <= i_source;
      o_pending <= next_pending;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  fetch_clear_a: assert property (i_ce && i_fetch && !hit |=> !o_pending) // RL8
    else $error("pending not cleared by vector fetch");
  sens_clear_a: assert property (i_ce && i_sens_change && !hit |=> !o_pending) // RL9
    else $error("pending not cleared by sensitivity change");
  rise_sets_a: assert property (i_ce && i_sens == 2'h1 && !prev && i_source |=> o_pending) // RL6
    else $error("rising edge did not set pending");
  fall_sets_a: assert property (i_ce && i_sens == 2'h0 && prev && !i_source |=> o_pending) // RL6
    else $error("falling edge did not set pending");

endmodule // gpx_ext_irq

//--- rtl/gpx_port.sv
// Eight-pin general-purpose I/O port with alternate functions and external interrupts.
// Function
// RL1 - Pin x uses bit x of each register.
// RL2 - Input mode reads back sampled pin level.
// RL3 - Input mode latch writes never drive pin.
// RL4 - Input option bit selects pull-up.
// RL5 - Input option bit enables pin interrupt.
// RL6 - Per-vector rising or falling sensitivity select.
// RL7 - Vector pins combine; one low masks others.
// RL8 - Vector fetch clears pending request.
// RL9 - Sensitivity change clears pending request.
// RL10 - Disabled interrupt pin feeds detector high.
// RL11 - Software enables interrupt via safe sequence.
// RL12 - Software disables interrupt via safe sequence.
// RL13 - Output mode drives and reads latch.
// RL14 - Output option picks push-pull or open-drain.
// RL15 - Peripheral output overrides port, stays readable.
// RL16 - Input plus peripheral output reads peripheral.
// RL17 - Output mode feeds latch to peripheral.
// RL18 - Floating input passes level to peripheral.
// RL19 - Low power keeps state; interrupt wakes. Low i_ce freezes detectors too; o_wake shows only requests pending before.
// RL20 - Software avoids bit read-modify-write on data.
// RL21 - Request needs interrupt mode and clear mask.
// RL22 - All bits reset to zero.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module gpx_port #(
  parameter int unsigned NUM_PINS = 8,
  parameter int unsigned NUM_VEC = 2,
  parameter logic [15:0] PIN_VEC_MAP = gpx_pkg::PIN_VEC_MAP_DEF
) (
  // Clock, reset and clock enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register port
  input wire logic [gpx_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gpx_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gpx_pkg::DATA_W-1:0] o_rdata,
  // Pads
  input wire logic [NUM_PINS-1:0] i_pin,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  output logic [NUM_PINS-1:0] o_pin_pullup,
  // Alternate functions of on-chip peripherals
  input wire logic [NUM_PINS-1:0] i_af_out_en,
  input wire logic [NUM_PINS-1:0] i_af_out,
  output logic [NUM_PINS-1:0] o_af_in,
  // Interrupt controller side
  input wire logic i_cpu_imask,
  input wire logic [NUM_VEC-1:0] i_vec_fetch,
  output logic [NUM_VEC-1:0] o_irq_req,
  output logic o_wake
);

  logic [NUM_PINS-1:0] latch;
  logic [NUM_PINS-1:0] dir;
  logic [NUM_PINS-1:0] opt;
  logic [gpx_pkg::DATA_W-1:0] sens;
  logic [NUM_PINS-1:0] pin_read;
  logic [NUM_PINS-1:0] pin_src;
  logic [NUM_VEC-1:0] vec_src;
  logic [NUM_VEC-1:0] sens_change;
  logic [NUM_VEC-1:0] pending;
  logic [gpx_pkg::DATA_W-1:0] rd_value;
  logic [gpx_pkg::DATA_W-1:0] next_rdata;
  wire logic wr_data;
  wire logic wr_dir;
  wire logic wr_opt;
  wire logic wr_sens;

  function automatic logic hits(input logic [gpx_pkg::ADDR_W-1:0] addr,
                                input logic [gpx_pkg::ADDR_W-1:0] offset);
    hits = (addr == offset);
  endfunction

  assign wr_data = i_wr & hits(i_addr, gpx_pkg::ADDR_DATA);
  assign wr_dir = i_wr & hits(i_addr, gpx_pkg::ADDR_DIR);
  assign wr_opt = i_wr & hits(i_addr, gpx_pkg::ADDR_OPT);
  assign wr_sens = i_wr & hits(i_addr, gpx_pkg::ADDR_SENS);

  // RL22 zero after reset
  // RL3 latch stores in any mode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      latch <= gpx_pkg::RST_LATCH[NUM_PINS-1:0];
      dir <= gpx_pkg::RST_DIR[NUM_PINS-1:0];
      opt <= gpx_pkg::RST_OPT[NUM_PINS-1:0];
      sens <= gpx_pkg::RST_SENS;
    end else if (i_ce) begin
      if (wr_data) begin
        latch <= i_wdata[NUM_PINS-1:0];
      end
      if (wr_dir) begin
        dir <= i_wdata[NUM_PINS-1:0];
      end
      if (wr_opt) begin
        opt <= i_wdata[NUM_PINS-1:0];
      end
      if (wr_sens) begin
        sens <= i_wdata;
      end
    end
  end

  // RL1 pin x on bit x
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      gpx_pin_cell u_cell (
        .i_latch(latch[p]),
        .i_dir(dir[p]),
        .i_opt(opt[p]),
        .i_pin(i_pin[p]),
        .i_af_out_en(i_af_out_en[p]),
        .i_af_out(i_af_out[p]),
        .o_out(o_pin_out[p]),
        .o_oe(o_pin_oe[p]),
        .o_pullup(o_pin_pullup[p]),
        .o_read(pin_read[p]),
        .o_af_in(o_af_in[p]),
        .o_irq_src(pin_src[p])
      );
    end
  endgenerate

  genvar v;
  genvar q;
  generate
    for (v = 0; v < NUM_VEC; v++) begin : g_vec
      localparam int unsigned VEC_NUM = v;
      logic [NUM_PINS-1:0] member;
      for (q = 0; q < NUM_PINS; q++) begin : g_member
        assign member[q] = (PIN_VEC_MAP[q*gpx_pkg::VEC_IDX_W +: gpx_pkg::VEC_IDX_W] ==
          VEC_NUM[gpx_pkg::VEC_IDX_W-1:0]);
      end
      // RL7 wired-and of group
      assign vec_src[v] = &(pin_src | ~member);
      // A rewrite with the same value keeps any pending request.
      assign sens_change[v] = wr_sens & i_ce &
        (i_wdata[v*gpx_pkg::SENS_W +: gpx_pkg::SENS_W] !=
         sens[v*gpx_pkg::SENS_W +: gpx_pkg::SENS_W]);
      gpx_ext_irq u_irq (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_source(vec_src[v]),
        .i_sens(sens[v*gpx_pkg::SENS_W +: gpx_pkg::SENS_W]),
        .i_sens_change(sens_change[v]),
        .i_fetch(i_vec_fetch[v]),
        .o_pending(pending[v])
      );
    end
  endgenerate

  // RL21 global mask gates request
  assign o_irq_req = pending & {NUM_VEC{~i_cpu_imask}};
  // RL19 pending wakes low power
  assign o_wake = |pending;

  // RL2 reads pin in input
  // RL13 reads latch in output
  always_comb begin
    rd_value = gpx_pkg::READ_NONE;
    if (hits(i_addr, gpx_pkg::ADDR_DATA)) begin
      rd_value[NUM_PINS-1:0] = pin_read;
    end else if (hits(i_addr, gpx_pkg::ADDR_DIR)) begin
      rd_value[NUM_PINS-1:0] = dir;
    end else if (hits(i_addr, gpx_pkg::ADDR_OPT)) begin
      rd_value[NUM_PINS-1:0] = opt;
    end else if (hits(i_addr, gpx_pkg::ADDR_SENS)) begin
      rd_value = sens;
    end else if (hits(i_addr, gpx_pkg::ADDR_PEND)) begin
      rd_value[NUM_VEC-1:0] = pending;
    end
  end

  // Read data stand for one enabled cycle only and hold while i_ce is low, so stale values never look like a new answer.
  assign next_rdata = i_rd ? rd_value : gpx_pkg::READ_NONE;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= gpx_pkg::READ_NONE;
    end else if (i_ce) begin
      o_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // RL1 checks
  latch_write_a: assert property (i_ce && wr_data |=> latch == $past(i_wdata[NUM_PINS-1:0])) // RL1
    else $error("data latch did not take the written value");
  // RL2 pin read back
  data_read_a: assert property (i_ce && i_rd && hits(i_addr, gpx_pkg::ADDR_DATA) // RL2
      && i_af_out_en == '0 |=> o_rdata[NUM_PINS-1:0] == $past((latch & dir) | (i_pin & ~dir)))
    else $error("data read returned the wrong source");
  // RL3 input never driven
  input_quiet_a: assert property ((o_pin_oe & ~dir & ~i_af_out_en) == '0) // RL3
    else $error("input pin is driven");
  // RL3 latch write quiet
  latch_quiet_a: assert property (i_ce && wr_data && dir == '0 && i_af_out_en == '0 // RL3
      |=> (o_pin_oe & ~i_af_out_en) == '0)
    else $error("latch write drove an input pin");
  // RL4 pull-up in input
  pullup_mode_a: assert property (o_pin_pullup == (~dir & opt & ~i_af_out_en)) // RL4
    else $error("pull-up does not follow input option");
  // RL4 pull-up off otherwise
  pullup_off_a: assert property ((o_pin_pullup & (dir | i_af_out_en)) == '0) // RL4
    else $error("pull-up on outside input mode");

  // RL13 output follows latch
  out_value_a: assert property (((o_pin_out ^ latch) & dir & ~i_af_out_en) == '0) // RL13
    else $error("output pin does not follow latch");
  // RL13 output reads latch
  out_read_a: assert property (i_ce && i_rd && hits(i_addr, gpx_pkg::ADDR_DATA) // RL13
      |=> ((o_rdata[NUM_PINS-1:0] ^ $past(latch)) & $past(dir & ~i_af_out_en)) == '0)
    else $error("output pin read did not return the latch");
  // RL13 read answers once
  rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == '0) // RL13
    else $error("read data stood longer than one cycle");
  // RL14 drive mode select
  drain_release_a: assert property ( // RL14
      (o_pin_oe & dir & ~opt & latch & ~i_af_out_en) == '0 &&
      (dir & opt & ~i_af_out_en & ~o_pin_oe) == '0)
    else $error("output drive mode wrong");
  // RL14 zero always drives
  drive_low_a: assert property ((dir & ~latch & ~i_af_out_en & ~o_pin_oe) == '0) // RL14
    else $error("latch zero not driven low");

  // RL15 peripheral takes pin
  af_override_a: assert property ((o_pin_oe & i_af_out_en) == i_af_out_en && // RL15
      (o_pin_out & i_af_out_en) == (i_af_out & i_af_out_en))
    else $error("peripheral output does not override port");
  // RL16 peripheral output readback
  af_read_a: assert property (i_ce && i_rd && hits(i_addr, gpx_pkg::ADDR_DATA) // RL16
      |=> ((o_rdata[NUM_PINS-1:0] ^ $past(i_af_out)) & $past(i_af_out_en)) == '0)
    else $error("data read ignores peripheral output");
  // RL17 peripheral input source
  af_input_a: assert property (o_af_in == ((dir & latch) | (~dir & i_pin))) // RL17
    else $error("peripheral input from wrong source");
  // RL18 floating input passes
  af_float_a: assert property (((o_af_in ^ i_pin) & ~dir) == '0) // RL18
    else $error("floating input not passed to peripheral");
  // RL10 disabled source high
  idle_high_a: assert property ((~pin_src & (dir | ~opt | i_af_out_en)) == '0) // RL10
    else $error("disabled pin does not idle high");
  // RL7 one low masks
  group_mask_a: assert property ((~pin_src & g_vec[0].member) != '0 |-> !vec_src[0]) // RL7
    else $error("low group pin did not mask vector");
  // RL21 global mask gate
  irq_gate_a: assert property (o_irq_req == (pending & {NUM_VEC{~i_cpu_imask}}) // RL21
      && o_wake == |pending)
    else $error("request not gated by global mask");
  // RL21 masked means silent
  mask_quiet_a: assert property (i_cpu_imask |-> o_irq_req == '0) // RL21
    else $error("request passed while masked");
  // RL19 pending wakes core
  wake_a: assert property (pending != '0 |-> o_wake) // RL19
    else $error("pending request does not wake");
  // RL19 clock enable freeze
  ce_freeze_a: assert property (!i_ce |=> $stable(latch) && $stable(dir) // RL19
      && $stable(opt) && $stable(sens) && $stable(pending) && $stable(o_rdata))
    else $error("state changed while clock enable low");

  // RL1 direction write lands
  dir_write_a: assert property (i_ce && wr_dir |=> dir == $past(i_wdata[NUM_PINS-1:0])) // RL1
    else $error("direction did not take the written value");
  // RL1 option write lands
  opt_write_a: assert property (i_ce && wr_opt |=> opt == $past(i_wdata[NUM_PINS-1:0])) // RL1
    else $error("option did not take the written value");
  // RL6 sensitivity write lands
  sens_write_a: assert property (i_ce && wr_sens |=> sens == $past(i_wdata)) // RL6
    else $error("sensitivity field did not take the written value");
  // RL9 same value keeps
  sens_keep_a: assert property (i_ce && wr_sens && i_wdata == sens && pending[0] // RL9
      && !i_vec_fetch[0] |=> pending[0])
    else $error("rewrite of same sensitivity cleared pending");
  // RL8 pending address write leaves latch, dir, opt and sens
  pend_ro_a: assert property (i_ce && i_wr && hits(i_addr, gpx_pkg::ADDR_PEND) // RL8
      |=> $stable(latch) && $stable(dir) && $stable(opt) && $stable(sens))
    else $error("write to pending address changed a register");
  // The edge checks tap the stored level of vector 0, since the source alone shows no edge.
  // RL5 interrupt pin edge
  pin_event_a: assert property (i_ce && sens[1:0] == 2'h0 && dir[0] == 1'b0 // RL5
      && opt[0] == 1'b1 && i_af_out_en[0] == 1'b0 && g_vec[0].u_irq.prev && !i_pin[0]
      && PIN_VEC_MAP[1:0] == 2'h0 |=> pending[0])
    else $error("falling edge on interrupt pin lost");
  // RL6 both edges set
  both_edge_a: assert property (i_ce && sens[1:0] == 2'h2 // RL6
      && g_vec[0].u_irq.prev != vec_src[0] |=> pending[0])
    else $error("edge in both-edge mode lost");
  // RL22 reset clears state
  reset_clear_a: assert property (disable iff (1'b0) $past(i_rst) // RL22
      |-> latch == '0 && dir == '0 && opt == '0 && pending == '0 && o_rdata == '0
      && sens == '0)
    else $error("state not cleared by reset");
  // RL22 reset quiets outputs
  reset_out_a: assert property (disable iff (1'b0) $past(i_rst) // RL22
      |-> (o_pin_oe & ~i_af_out_en) == '0 && o_pin_pullup == '0 && o_irq_req == '0
      && o_wake == '0)
    else $error("outputs not quiet after reset");

  pend_set_c: cover property (i_ce && !pending[0] ##1 pending[0]);
  fetch_c: cover property (pending[0] && i_vec_fetch[0] && i_ce ##1 !pending[0]);
  af_drive_c: cover property (i_af_out_en[0] && !dir[0]);
  drain_c: cover property (dir[0] && !opt[0] && latch[0] && !o_pin_oe[0]);
  ce_hold_c: cover property (!i_ce && wr_dir);

endmodule // gpx_port

//--- bench/gpx_pad_model.sv
// Behavioural model of the external pads that face the port.
`timescale 1ns/100ps
module gpx_pad_model (
  // Clock
  input wire logic i_clock,
  // Port side
  input wire logic [7:0] i_pin_out,
  input wire logic [7:0] i_pin_oe,
  input wire logic [7:0] i_pin_pullup,
  // External driver
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  // Resolved wire level
  output logic [7:0] o_pad
);
  logic [7:0] last_level = 8'h00;
  // An undriven pad without pull-up drifts, so it never simply keeps its last value.
  assign o_pad = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
    | (~i_pin_oe & ~i_ext_en & (i_pin_pullup | ~last_level));
  always_ff @(posedge i_clock) begin
    last_level <= o_pad;
  end
endmodule // gpx_pad_model

//--- bench/gpx_port_tb.sv
// Self-checking bench of the port: registers, pads, alternate functions, interrupts.
`timescale 1ns/100ps
module gpx_port_tb;
  localparam logic [3:0] A_DAT = gpx_pkg::ADDR_DATA;
  localparam logic [3:0] A_DIR = gpx_pkg::ADDR_DIR;
  localparam logic [3:0] A_OPT = gpx_pkg::ADDR_OPT;
  localparam logic [3:0] A_SEN = gpx_pkg::ADDR_SENS;
  localparam logic [3:0] A_PND = gpx_pkg::ADDR_PEND;
  logic i_clock, i_rst, i_ce, i_wr, i_rd, i_cpu_imask, o_wake;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, i_af_out_en, i_af_out, ext_en, ext_val, pad;
  logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_pin_pullup, o_af_in;
  logic [1:0] i_vec_fetch, o_irq_req;
  int err_total = 0;
  int n_checks = 0;

  gpx_port dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(pad),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
    .i_af_out_en(i_af_out_en), .i_af_out(i_af_out), .o_af_in(o_af_in),
    .i_cpu_imask(i_cpu_imask), .i_vec_fetch(i_vec_fetch), .o_irq_req(o_irq_req),
    .o_wake(o_wake));
  gpx_pad_model pads (.i_clock(i_clock), .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pin_pullup(o_pin_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk("rdata", exp, o_rdata);
  endtask

  task automatic drv(input logic [7:0] en, val, afe, afo);
    @(posedge i_clock);
    ext_en <= en;
    ext_val <= val;
    i_af_out_en <= afe;
    i_af_out <= afo;
    #1;
  endtask

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  task automatic fetch(input logic [1:0] v);
    @(posedge i_clock);
    i_vec_fetch <= v;
    @(posedge i_clock);
    i_vec_fetch <= 2'h0;
    #1;
  endtask

  initial begin
    #(100 * 3000);
    err_total++;
    end_of_test();
  end

  initial begin
    {i_rst, i_cpu_imask, i_ce, ext_en, ext_val} = {3'h7, 8'hff, 8'ha5};
    {i_wr, i_rd, i_addr, i_wdata, i_vec_fetch, i_af_out_en, i_af_out} = '0;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int a = 1; a < 8; a++) rd(a[3:0], 8'h00);
    chk("oe", 8'h00, o_pin_oe);
    chk("pullup", 8'h00, o_pin_pullup);
    rd(A_DAT, 8'ha5);
    // The data register is only ever written as a whole byte, never bit by bit.
    wr(A_DAT, 8'h3c);
    chk("oe", 8'h00, o_pin_oe);
    rd(A_DAT, 8'ha5);
    drv(8'hff, 8'hff, 8'h00, 8'h00);
    wr(A_OPT, 8'hff);
    chk("pullup", 8'hff, o_pin_pullup);
    wr(A_DIR, 8'hff);
    drv(8'h00, 8'hff, 8'h00, 8'h00);
    chk("oe", 8'hff, o_pin_oe);
    chk("out", 8'h3c, o_pin_out);
    rd(A_DAT, 8'h3c);
    chk("af_in", 8'h3c, o_af_in);
    wr(A_OPT, 8'h00);
    chk("oe", 8'hc3, o_pin_oe);
    chk("out", 8'h00, o_pin_out & o_pin_oe);
    drv(8'hff, 8'ha4, 8'h01, 8'h01);
    wr(A_DIR, 8'h00);
    chk("oe", 8'h01, o_pin_oe);
    rd(A_DAT, 8'ha5);
    drv(8'hff, 8'ha5, 8'h00, 8'h00);
    chk("af_in", 8'ha5, o_af_in);
    drv(8'hff, 8'hff, 8'h00, 8'h00);
    // Safe enabling sequence with the mask set.
    wr(A_SEN, 8'h01);
    wr(A_OPT, 8'h01);
    wr(A_SEN, 8'h00);
    rd(A_PND, 8'h00);
    drv(8'hff, 8'hfe, 8'h00, 8'h00);
    tick();
    chk("irq", 8'h00, {6'h00, o_irq_req});
    chk("wake", 8'h01, {7'h00, o_wake});
    @(posedge i_clock) i_cpu_imask <= 1'b0;
    #1;
    chk("irq", 8'h01, {6'h00, o_irq_req});
    fetch(2'h1);
    chk("wake", 8'h00, {7'h00, o_wake});
    drv(8'hff, 8'hff, 8'h00, 8'h00);
    drv(8'hff, 8'hfe, 8'h00, 8'h00);
    tick();
    wr(A_SEN, 8'h00);
    rd(A_PND, 8'h01);
    wr(A_SEN, 8'h02);
    rd(A_PND, 8'h00);
    drv(8'hff, 8'hff, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h01);
    wr(A_SEN, 8'h01);
    drv(8'hff, 8'hfe, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h00);
    drv(8'hff, 8'hff, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h01);
    wr(A_SEN, 8'h03);
    rd(A_PND, 8'h00);
    wr(A_SEN, 8'h00);
    wr(A_OPT, 8'h03);
    drv(8'hff, 8'hfd, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h01);
    fetch(2'h1);
    drv(8'hff, 8'hfc, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h00);
    wr(A_OPT, 8'h00);
    rd(A_PND, 8'h00);
    wr(A_OPT, 8'h01);
    tick();
    rd(A_PND, 8'h01);
    wr(A_SEN, 8'h04);
    wr(A_OPT, 8'h11);
    drv(8'hff, 8'hec, 8'h00, 8'h00);
    tick();
    drv(8'hff, 8'hfc, 8'h00, 8'h00);
    tick();
    rd(A_PND, 8'h03);
    chk("irq", 8'h03, {6'h00, o_irq_req});
    // Safe disabling sequence.
    wr(A_SEN, 8'h00);
    wr(A_OPT, 8'h00);
    wr(A_SEN, 8'h05);
    rd(A_PND, 8'h00);
    wr(A_PND, 8'hff);
    rd(A_PND, 8'h00);
    // A stopped clock enable stands for a low-power state: nothing may change.
    @(posedge i_clock) i_ce <= 1'b0;
    wr(A_DIR, 8'h0f);
    chk("oe", 8'h00, o_pin_oe);
    @(posedge i_clock) i_ce <= 1'b1;
    rd(A_DIR, 8'h00);
    end_of_test();
  end
endmodule // gpx_port_tb
